// File: src/adc_seq_pkg.sv
package adc_seq_pkg;
   // ==========================================================
   // register byte offsets (APB, one word each)
   localparam logic [7:0] OFF_CTRL1  = 8'h00;
   localparam logic [7:0] OFF_CTRL2  = 8'h04;
   localparam logic [7:0] OFF_CTRL4  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_DMAADR = 8'h14;
   localparam logic [7:0] OFF_INPUT  = 8'h18;
   // ==========================================================
   // ctrl1 field positions
   localparam int B_SAMPLE  = 1;
   localparam int B_AUTO    = 2;
   localparam int B_SIMSEL  = 3;
   localparam int B_ORDER   = 12;
   localparam int B_MODON   = 15;
   localparam int B_TRIG_LO = 5;
   localparam int B_TRIG_HI = 7;
   // ctrl2 field positions
   localparam int B_SPI_LO  = 2;
   localparam int B_SPI_HI  = 5;
   localparam int B_CHC_LO  = 8;
   localparam int B_CHC_HI  = 9;
   localparam int B_IRQEN   = 0;
   // ctrl4 field positions
   localparam int B_DEP_LO  = 0;
   localparam int B_DEP_HI  = 2;
   // status bits
   localparam int B_DONE    = 0;
   localparam int B_BUSY    = 1;
   localparam int B_IRQ     = 2;
   // ==========================================================
   // trigger code that converts on a software sample clear
   localparam logic [2:0] TRIG_MANUAL = 3'h0;
   // timing: conversion length in ns, cycles at 4 ns
   localparam int CONV_NS  = 400;
   localparam int CLK_NS   = 4;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   // reset values
   localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage : adc_seq_pkg

// File: src/div_counter.sv
`timescale 1ns/1ps
// wrapping counter, emits wrap pulse when it rolls over at limit
module div_counter #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // control
   input  wire logic         clr,
   input  wire logic         inc,
   input  wire logic [W-1:0] limit,
   // state
   output logic      [W-1:0] count,
   output logic              wrap
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } st_type;
   st_type st_reg;
   st_type st_next;

   // wrap at or past the limit, so a limit lowered under the count
   // recovers on the next bump instead of running round the full range
   assign wrap  = inc && (st_reg.cnt >= limit);
   assign count = st_reg.cnt;

   // ==========================================================
   // next-state
   always_comb begin
      st_next = st_reg;
      if (clr) begin
         st_next.cnt = '0;
      end else if (inc) begin
         st_next.cnt = wrap ? '0 : st_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : div_counter

// File: src/adc_seq_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - done flag sets when conversion finishes
// - idle after reset or off shows sample and done both zero
// - interrupt every seq_per_irq+1 sequences
// - each conversion overwrites result_word
// - sequential select: one sample per result
// - simultaneous: channels per sample results
// - conv_irq_enable and module on gate the interrupt
// - manual sample clear converts if trigger 000
// - auto arm clear stops further restarts
// - module off aborts, result kept
// - single read-only result word
// - dma request on each conversion result
// - order mode gives plain result address
// - scatter address from input and block
// - block depth from per_input_depth
// - pointer clears on enable, wraps at depth
// - pointer advances every seq_per_irq+1
// - order mode holds the pointer, same word for every result
// - auto arm starts sampling, trigger converts
module adc_seq_ctrl
   import adc_seq_pkg::*;
#(
   parameter int DW = 16,
   parameter int IW = 5
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // converter front end
   input  wire logic          conv_trigger,
   input  wire logic [DW-1:0] conv_data,
   input  wire logic [IW-1:0] input_index,
   // dma and interrupt
   output logic               dma_req,
   output logic      [15:0]   dma_addr,
   output logic               conv_irq
);
   import adc_seq_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b001,
      S_SAMPLE = 3'b010,
      S_CONV   = 3'b100
   } phase_type;

   typedef struct packed {
      phase_type     ph;
      logic          on;
      logic          arm;
      logic          simsel;
      logic          order;
      logic [2:0]    trig;
      logic [3:0]    spi;
      logic [1:0]    chc;
      logic          irqen;
      logic [2:0]    depth;
      logic          done;
      logic          irq;
      logic          dreq;
      logic [15:0]   daddr;
      logic [DW-1:0] result;
      logic [7:0]    ccnt;
      logic [1:0]    chn;
      logic [IW-1:0] lastin;
      logic [31:0]   rdata;
   } st_type;

   st_type st_reg;
   st_type st_next;

   logic       wr;
   logic       rd;
   logic       seq_end;
   logic [3:0] seq_cnt;
   logic       seq_wrap;
   logic [6:0] blk_ptr;
   logic       blk_wrap;
   logic [6:0] blk_lim;
   logic       on_rise;
   logic       map_hit;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign map_hit = (paddr <= OFF_INPUT) && (paddr[1:0] == 2'h0);
   // zero wait states, unmapped addresses flag an error
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !map_hit;
   assign prdata  = st_reg.rdata;

   // last channel of a sequence ends it
   assign seq_end = (st_reg.ph == S_CONV) && (st_reg.ccnt == 8'h00) &&
                    (st_reg.simsel ? (st_reg.chn == st_reg.chc) : 1'b1);
   // enable edge restarts the block pointer
   assign on_rise = wr && (paddr == OFF_CTRL1) && pwdata[B_MODON] &&
                    !st_reg.on;
   // depth code n means 2**n words, pointer limit is one less
   assign blk_lim = 7'((8'h01 << st_reg.depth) - 8'h01);

   // ==========================================================
   // sequence counter: interrupt interval
   div_counter #(.W(4)) u_seq (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clr     (on_rise),
      .inc     (seq_end),
      .limit   (st_reg.spi),
      .count   (seq_cnt),
      .wrap    (seq_wrap)
   );

   // block pointer, stepped every seq_per_irq+1 sequences, held in order mode
   div_counter #(.W(7)) u_blk (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clr     (on_rise),
      .inc     (seq_wrap && !st_reg.order),
      .limit   (blk_lim),
      .count   (blk_ptr),
      .wrap    (blk_wrap)
   );

   // ==========================================================
   // next-state: registers, sequencer, result and dma
   always_comb begin
      st_next      = st_reg;
      st_next.dreq = 1'b0;
      st_next.irq  = 1'b0;
      // register writes
      if (wr && paddr == OFF_CTRL1) begin
         st_next.on     = pwdata[B_MODON];
         st_next.arm    = pwdata[B_AUTO];
         st_next.simsel = pwdata[B_SIMSEL];
         st_next.order  = pwdata[B_ORDER];
         st_next.trig   = pwdata[B_TRIG_HI:B_TRIG_LO];
      end
      if (wr && paddr == OFF_CTRL2) begin
         st_next.spi   = pwdata[B_SPI_HI:B_SPI_LO];
         st_next.chc   = pwdata[B_CHC_HI:B_CHC_LO];
         st_next.irqen = pwdata[B_IRQEN];
      end
      if (wr && paddr == OFF_CTRL4) begin
         st_next.depth = pwdata[B_DEP_HI:B_DEP_LO];
      end
      // sequencer
      case (st_reg.ph)
         S_IDLE: begin
            // software sample start, or auto arm
            if (st_next.on && (st_next.arm ||
                (wr && paddr == OFF_CTRL1 && pwdata[B_SAMPLE]))) begin
               st_next.ph   = S_SAMPLE;
               st_next.done = 1'b0;
            end
         end
         S_SAMPLE: begin
            if (wr && paddr == OFF_CTRL1 && !pwdata[B_SAMPLE] &&
                !st_reg.arm) begin
               // manual clear ends sampling; converts on code 000
               st_next.ph = (st_reg.trig == TRIG_MANUAL) ?
                            S_CONV : S_IDLE;
            end else if (st_reg.trig != TRIG_MANUAL && conv_trigger) begin
               st_next.ph = S_CONV;
            end
            st_next.ccnt = 8'(CONV_CYC - 1);
            st_next.chn  = 2'h0;
         end
         S_CONV: begin
            if (st_reg.ccnt != 8'h00) begin
               st_next.ccnt = st_reg.ccnt - 8'h01;
            end else begin
               // each result overwrites the single word
               st_next.result = conv_data;
               st_next.lastin = input_index;
               st_next.dreq   = 1'b1;
               // order mode: same address as the stand-alone word
               st_next.daddr  = st_reg.order ? 16'(OFF_RESULT)
                              : 16'({input_index, 7'h00} >>
                                 (3'h7 - st_reg.depth)) |
                                16'(blk_ptr);
               if (st_reg.simsel && st_reg.chn != st_reg.chc) begin
                  // simultaneous: one result per held channel
                  st_next.chn  = st_reg.chn + 2'h1;
                  st_next.ccnt = 8'(CONV_CYC - 1);
               end else begin
                  // sequence end: sequential result or last held channel
                  st_next.done = 1'b1;
                  st_next.ph   = st_reg.arm ? S_SAMPLE : S_IDLE;
                  st_next.irq  = seq_wrap && st_reg.irqen;
               end
            end
         end
         default: st_next.ph = S_IDLE;
      endcase
      // module off aborts whatever runs, result left alone
      if (!st_next.on) begin
         st_next.ph     = S_IDLE;
         st_next.result = st_reg.result;
         st_next.dreq   = 1'b0;
         st_next.irq    = 1'b0;
         st_next.done   = 1'b0;
      end
      // read mux, captured in the setup phase
      st_next.rdata = 32'h0;
      if (rd) begin
         case (paddr)
            OFF_CTRL1:  st_next.rdata = 32'({st_reg.on, 2'h0,
                           st_reg.order, 4'h0, st_reg.trig, 1'b0,
                           st_reg.simsel, st_reg.arm,
                           st_reg.ph == S_SAMPLE, st_reg.done});
            OFF_CTRL2:  st_next.rdata = 32'({st_reg.chc, 2'h0,
                           st_reg.spi, 1'b0, st_reg.irqen});
            OFF_CTRL4:  st_next.rdata = 32'(st_reg.depth);
            OFF_STATUS: st_next.rdata = 32'({seq_cnt,
                           st_reg.ph == S_SAMPLE || st_reg.ph == S_CONV,
                           st_reg.done});
            OFF_RESULT: st_next.rdata = 32'(st_reg.result);
            OFF_DMAADR: st_next.rdata = 32'({blk_ptr, st_reg.daddr});
            OFF_INPUT:  st_next.rdata = 32'(st_reg.lastin);
            default:    st_next.rdata = 32'h0;
         endcase
      end
   end

   assign dma_req  = st_reg.dreq;
   assign dma_addr = st_reg.daddr;
   assign conv_irq = st_reg.irq;

   // ==========================================================
   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_reg        <= '0;
         st_reg.ph     <= S_IDLE;
         st_reg.result <= DW'(RESULT_RST);
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // checks
   property p_idle_flags;
      @(posedge ref_clk) disable iff (!rst_n)
      !st_reg.on |-> st_reg.ph == S_IDLE && !st_reg.done;
   endproperty
   a_idle_flags: assert property (p_idle_flags)
      else $error("off module not idle");

   property p_irq_gate;
      @(posedge ref_clk) disable iff (!rst_n)
      conv_irq |-> $past(st_reg.irqen);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt without enable");

   property p_dreq_done;
      @(posedge ref_clk) disable iff (!rst_n)
      $past(seq_end) && st_reg.on |-> dma_req;
   endproperty
   a_dreq_done: assert property (p_dreq_done)
      else $error("no dma request at sequence end");

   property p_keep_result;
      @(posedge ref_clk) disable iff (!rst_n)
      !st_reg.on |=> $stable(st_reg.result);
   endproperty
   a_keep_result: assert property (p_keep_result)
      else $error("result changed while off");

   property p_order_addr;
      @(posedge ref_clk) disable iff (!rst_n)
      dma_req && $past(st_reg.order) |-> dma_addr == 16'(OFF_RESULT);
   endproperty
   a_order_addr: assert property (p_order_addr)
      else $error("order mode address wrong");

   property p_done_set;
      @(posedge ref_clk) disable iff (!rst_n)
      seq_end && st_reg.on && st_next.on |=> st_reg.done;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done not set");

   property p_ptr_lim;
      @(posedge ref_clk) disable iff (!rst_n)
      st_reg.on |-> blk_ptr <= blk_lim;
   endproperty
   a_ptr_lim: assert property (p_ptr_lim)
      else $error("pointer past depth");

   property p_no_restart;
      @(posedge ref_clk) disable iff (!rst_n)
      seq_end && !st_reg.arm |=> st_reg.ph != S_SAMPLE;
   endproperty
   a_no_restart: assert property (p_no_restart)
      else $error("restart without arm");

   // window for one channel: counter length plus a cycle of slack
   localparam int CONV_WIN = CONV_CYC + 1;

   // software clear of the sample bit, module left running
   sequence s_sample_clear;
      wr && paddr == OFF_CTRL1 && !pwdata[B_SAMPLE] && pwdata[B_MODON] &&
      st_reg.ph == S_SAMPLE && !st_reg.arm;
   endsequence

   property p_manual_conv;
      @(posedge ref_clk) disable iff (!rst_n)
      s_sample_clear ##0 (st_reg.trig == TRIG_MANUAL) |=>
         st_reg.ph == S_CONV;
   endproperty
   a_manual_conv: assert property (p_manual_conv)
      else $error("manual clear did not convert");

   // other trigger codes wait for their own event, so back to idle
   property p_clear_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      s_sample_clear ##0 (st_reg.trig != TRIG_MANUAL) |=>
         st_reg.ph == S_IDLE;
   endproperty
   a_clear_idle: assert property (p_clear_idle)
      else $error("sample clear converted without code 000");

   // arming from idle starts sampling at once
   property p_auto_start;
      @(posedge ref_clk) disable iff (!rst_n)
      wr && paddr == OFF_CTRL1 && pwdata[B_MODON] && pwdata[B_AUTO] &&
      st_reg.ph == S_IDLE |=> st_reg.ph == S_SAMPLE;
   endproperty
   a_auto_start: assert property (p_auto_start)
      else $error("armed module did not sample");

   // a started conversion delivers a result unless switched off
   sequence s_conv_entry;
      $rose(st_reg.ph == S_CONV) && st_reg.on;
   endsequence

   sequence s_result_out;
      dma_req || !st_reg.on;
   endsequence

   property p_conv_len;
      @(posedge ref_clk) disable iff (!rst_n)
      s_conv_entry |-> ##[1:CONV_WIN] s_result_out;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("no result within conversion time");
endmodule : adc_seq_ctrl

// File: dv/dma_sink.sv
`timescale 1ns/1ps
// ==========
// dma channel and cpu interrupt stand-in, counts what it is handed
module dma_sink #(
   parameter logic [15:0] BASE = 16'h8000
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // request side
   input  wire logic        dma_req,
   input  wire logic [15:0] dma_addr,
   input  wire logic        conv_irq,
   // observed counts
   output int               req_cnt,
   output int               irq_cnt,
   output logic      [15:0] last_addr
);
   // peripheral indirect: the block address is or-ed onto an aligned
   // base, so a misaligned base would corrupt blocks silently
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         req_cnt   <= 0;
         irq_cnt   <= 0;
         last_addr <= 16'h0000;
      end else begin
         if (dma_req) begin
            req_cnt   <= req_cnt + 1;
            last_addr <= BASE | dma_addr;
         end
         if (conv_irq) irq_cnt <= irq_cnt + 1;
      end
   end
endmodule : dma_sink

// File: dv/adc_sequence_dma_buffering_bench.sv
`timescale 1ns/1ps
// ==========
// bench: apb master, integer model of pointer and sequence counts
module adc_sequence_dma_buffering_bench;
   import adc_seq_pkg::*;
   localparam logic [15:0] DBASE = 16'h8000;
   // config table: ctrl1, ctrl2, ctrl4; order mode keeps spi zero
   localparam logic [31:0] T1 [4] = '{32'h8000, 32'h9000, 32'h8000, 32'h8000};
   localparam logic [31:0] T2 [4] = '{32'h0005, 32'h0001, 32'h000c, 32'h0001};
   localparam logic [31:0] T4 [4] = '{32'h0002, 32'h0005, 32'h0001, 32'h0007};
   logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        rd_err, conv_trigger, dma_req, conv_irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_data, rng, c1;
   logic [15:0] conv_data, dma_addr, last_addr, keep;
   logic [4:0]  input_index;
   int          error_cnt, cmp_count, req_cnt, irq_cnt, b;
   int          m_ptr, m_seq, m_irq, m_spi, m_dep, m_en, m_ord;

   adc_seq_ctrl #(.DW(16), .IW(5)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_trigger(conv_trigger),
      .conv_data(conv_data), .input_index(input_index),
      .dma_req(dma_req), .dma_addr(dma_addr), .conv_irq(conv_irq));
   dma_sink #(.BASE(DBASE)) sink (
      .ref_clk(ref_clk), .rst_n(rst_n), .dma_req(dma_req),
      .dma_addr(dma_addr), .conv_irq(conv_irq), .req_cnt(req_cnt),
      .irq_cnt(irq_cnt), .last_addr(last_addr));

   // 250 mhz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ==========
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tk
   task automatic end_sim;
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer; an idle edge follows so psel never toggles twice
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      tk(1);
      penable <= 1'b1;
      do begin
         tk(1);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) begin
         error_cnt++;
         end_sim();
      end
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      tk(1);
   endtask : apb
   task automatic wait_req(input int base);
      int n;
      n = 0;
      while (req_cnt == base && n < 800) begin
         tk(1);
         n++;
      end
      if (n >= 800) begin
         error_cnt++;
         end_sim();
      end
   endtask : wait_req
   task automatic pulse;
      conv_trigger <= 1'b1;
      tk(1);
      conv_trigger <= 1'b0;
      tk(1);
   endtask : pulse
   // software sample start then clear; trigger code 000 converts
   task automatic conv_sw;
      apb(1'b1, OFF_CTRL1, c1 | 32'h2);
      apb(1'b1, OFF_CTRL1, c1);
   endtask : conv_sw
   // off then on, so pointer and sequence count restart at zero
   task automatic cfg(input logic [31:0] a, x, y);
      apb(1'b1, OFF_CTRL1, 32'h0);
      apb(1'b1, OFF_CTRL2, x);
      apb(1'b1, OFF_CTRL4, y);
      apb(1'b1, OFF_CTRL1, a);
      c1 = a;
      m_ptr = 0;
      m_seq = 0;
      m_ord = a[B_ORDER];
      m_spi = x[B_SPI_HI:B_SPI_LO];
      m_dep = y[B_DEP_HI:B_DEP_LO];
      m_en = x[B_IRQEN];
   endtask : cfg
   // one sequence with random data and input, compared with the model
   task automatic seq_chk;
      logic [15:0] ea;
      logic [4:0]  ix;
      rng = xs(rng);
      // scans and alternate sampling step through spi+1 inputs
      ix = (m_spi != 0) ? 5'(m_seq) : rng[20:16];
      conv_data   <= rng[15:0];
      input_index <= ix;
      b = req_cnt;
      conv_sw();
      wait_req(b);
      ea = 16'((ix << m_dep) | m_ptr);
      m_seq++;
      if (m_seq > m_spi) begin
         m_seq = 0;
         m_ptr = (m_ptr + 1) % (1 << m_dep);
         m_irq += m_en;
      end
      if (m_ord) chk("ord", DBASE | 16'(OFF_RESULT), last_addr);
      else chk("sga", DBASE|ea, last_addr);
      chk("reqs", b + 1, req_cnt);
      tk(4);
      chk("irqs", m_irq, irq_cnt);
      apb(1'b0, OFF_RESULT, 0);
      chk("result", rng[15:0], rd_data);
      apb(1'b0, OFF_INPUT, 0);
      chk("input", ix, rd_data);
      apb(1'b0, OFF_CTRL1, 0);
      chk("done", 2'b01, rd_data[1:0]);
   endtask : seq_chk
   // ==========
   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      conv_trigger = 1'b0;
      conv_data = 16'h0;
      input_index = 5'h0;
      rng = 32'h870cd942;
      error_cnt = 0;
      cmp_count = 0;
      m_irq = 0;
      tk(16);
      rst_n <= 1'b1;
      tk(1);
      apb(1'b0, OFF_CTRL1, 0);
      chk("idle", 2'b00, rd_data[1:0]);
      apb(1'b0, 8'h1c, 0);
      chk("slverr", 1'b1, rd_err);
      chk("unmapped", 0, rd_data);
      for (int i = 0; i < 4; i++) begin
         cfg(T1[i], T2[i], T4[i]);
         repeat (9) seq_chk();
      end
      apb(1'b1, OFF_RESULT, 32'hffff);
      apb(1'b0, OFF_RESULT, 0);
      chk("ro_result", rng[15:0], rd_data);
      // abort mid conversion: nothing delivered, old result kept
      cfg(32'h8000, 32'h0, 32'h0);
      keep = rng[15:0];
      conv_data <= ~rng[15:0];
      b = req_cnt;
      conv_sw();
      tk(20);
      apb(1'b0, OFF_STATUS, 0);
      chk("busy", 2'b10, rd_data[1:0]);
      apb(1'b1, OFF_CTRL1, 32'h0);
      tk(150);
      chk("abort_req", b, req_cnt);
      apb(1'b0, OFF_RESULT, 0);
      chk("abort_res", keep, rd_data);
      // trigger code other than 000: clearing sample does not convert
      cfg(32'h8020, 32'h0, 32'h0);
      conv_sw();
      tk(150);
      chk("no_conv", b, req_cnt);
      apb(1'b1, OFF_CTRL1, 32'h8022);
      pulse();
      wait_req(b);
      chk("trig_conv", b + 1, req_cnt);
      // auto arm, then disarm during a conversion
      cfg(32'h8024, 32'h0, 32'h0);
      apb(1'b0, OFF_CTRL1, 0);
      chk("auto_sample_active", 1'b1, rd_data[B_SAMPLE]);
      b = req_cnt;
      pulse();
      wait_req(b);
      tk(4);
      apb(1'b0, OFF_CTRL1, 0);
      chk("resample", 1'b1, rd_data[B_SAMPLE]);
      b = req_cnt;
      pulse();
      tk(10);
      apb(1'b1, OFF_CTRL1, 32'h8020);
      wait_req(b);
      tk(4);
      apb(1'b0, OFF_CTRL1, 0);
      chk("no_resample", 1'b0, rd_data[B_SAMPLE]);
      b = req_cnt;
      pulse();
      tk(150);
      chk("stopped", b, req_cnt);
      // four channels per sample: sequential gives one result only
      for (int s = 0; s < 2; s++) begin
         cfg(32'h8000 | (s << B_SIMSEL), 32'h0300, 32'h0);
         b = req_cnt;
         conv_sw();
         tk(600);
         chk("results", b + (s ? 4 : 1), req_cnt);
      end
      end_sim();
   end
endmodule : adc_sequence_dma_buffering_bench
